// File: dhg_top.v
// dhg_top.v - debug halt, restart handshake, permission and access gating.
// assumes: halt request and trace halt come from core-clock logic; debug port
// pins, the port clock and the tap reset are asynchronous and get synchronised.
//
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "dhg_regs.vh"

module dhg_top (
    input wire clk_i,
    input wire nrst_i,
    input wire ce_i,
    // register port
    input wire [`DHG_ADDR_W-1:0] addr_i,
    input wire [`DHG_STAT_W-1:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [`DHG_STAT_W-1:0] rdata_o,
    // halt control, core clock domain
    input wire ext_halt_req_i,
    input wire trace_halt_req_i,
    input wire halt_exit_req_i,
    output reg halt_exit_ack_o,
    output reg core_halted_flag_o,
    // permissions
    input wire invasive_dbg_allow_i,
    input wire noninvasive_dbg_allow_i,
    input wire ap_mem_access_allow_i,
    input wire ap_master_id_lock_i,
    output reg trace_allow_o,
    // access port memory side
    output reg ap_bus_req_o,
    output reg [3:0] ap_hmaster_o,
    // debug port pins
    input wire dbg_port_clock_i,
    input wire dbg_tap_reset_n_i,
    input wire tms_i,
    input wire tdi_i,
    output reg port_proto_select_o,
    output reg tap_top_state_flag_o,
    output reg sw_data_out_o,
    output reg sw_data_out_en_o,
    output reg tdo_o,
    output reg tdo_pad_en_n_o
);

    // ==========================================================
    // halt state machine codes
    localparam ST_RUN = 2'b00;
    localparam ST_HALT = 2'b01;
    localparam ST_ACK = 2'b10;
    localparam ST_DROP = 2'b11;

    reg [`DHG_CTRL_W-1:0] ctrl;
    reg [`DHG_APCTL_W-1:0] apctl;
    reg [1:0] hstate;
    reg [1:0] next_hstate;
    reg [`DHG_STAT_W-1:0] next_rdata;
    reg [2:0] tck_sync;
    reg [1:0] trst_sync;
    reg [1:0] tms_sync;
    reg [1:0] tdi_sync;
    reg tdo_shift;
    wire [`DHG_TAP_W-1:0] tap_state;
    wire halt_src;
    wire halt_allowed;
    wire tck_rise;
    wire tck_fall;
    wire tap_top;
    wire shifting;

    // ==========================================================
    // halt source merge and permission gating
    assign halt_src = ext_halt_req_i | trace_halt_req_i | ctrl[`DHG_CTRL_HALT_REQ]; // R2 R1
    assign halt_allowed = invasive_dbg_allow_i & ctrl[`DHG_CTRL_HALT_EN]; // R6 R7

    // ==========================================================
    // register writes
    always @(posedge clk_i) begin
        if (!nrst_i) begin
            ctrl <= `DHG_CTRL_RESET;
            apctl <= `DHG_APCTL_RESET;
        end else if (ce_i && wr_i) begin
            if (addr_i == `DHG_REG_CTRL) begin
                ctrl <= wdata_i[`DHG_CTRL_W-1:0];
            end
            if (addr_i == `DHG_REG_APCTL) begin
                apctl <= wdata_i[`DHG_APCTL_W-1:0];
            end
        end
    end

    // ==========================================================
    // read mux, data one cycle after the strobe
    always @* begin
        next_rdata = {`DHG_STAT_W{1'b0}};
        case (addr_i)
            `DHG_REG_CTRL: next_rdata[`DHG_CTRL_W-1:0] = ctrl;
            `DHG_REG_APCTL: next_rdata[`DHG_APCTL_W-1:0] = apctl;
            `DHG_REG_STAT: begin
                next_rdata[`DHG_STAT_HALTED] = core_halted_flag_o;
                next_rdata[`DHG_STAT_ACK] = halt_exit_ack_o;
                next_rdata[`DHG_STAT_JTAG] = port_proto_select_o;
                next_rdata[`DHG_STAT_TOP] = tap_top_state_flag_o;
            end
            default: next_rdata = {`DHG_STAT_W{1'b0}};
        endcase
    end

    always @(posedge clk_i) begin
        if (!nrst_i) begin
            rdata_o <= {`DHG_STAT_W{1'b0}};
        end else if (ce_i) begin
            rdata_o <= rd_i ? next_rdata : {`DHG_STAT_W{1'b0}};
        end
    end

    // ==========================================================
    // halt and four-phase restart handshake
    always @* begin
        next_hstate = hstate;
        case (hstate)
            ST_RUN: begin
                if (halt_src && halt_allowed) begin
                    next_hstate = ST_HALT;
                end
            end
            ST_HALT: begin
                if (halt_exit_req_i) begin
                    next_hstate = ST_ACK; // R5
                end
            end
            ST_ACK: begin
                if (!halt_exit_req_i) begin
                    next_hstate = ST_DROP; // R3
                end
            end
            ST_DROP: next_hstate = ST_RUN; // R5
            default: next_hstate = ST_RUN;
        endcase
    end

    // halt state; a source still high after the restart re-halts after one run cycle
    always @(posedge clk_i) begin
        if (!nrst_i) begin
            hstate <= ST_RUN;
            halt_exit_ack_o <= 1'b0;
            core_halted_flag_o <= 1'b0;
        end else if (ce_i) begin
            hstate <= next_hstate;
            halt_exit_ack_o <= (next_hstate == ST_ACK); // R4
            core_halted_flag_o <= (next_hstate == ST_HALT) | (next_hstate == ST_ACK); // R18
        end
    end

    // ==========================================================
    // trace permission and access port gating
    always @(posedge clk_i) begin
        if (!nrst_i) begin
            trace_allow_o <= 1'b0;
            ap_bus_req_o <= 1'b0;
            ap_hmaster_o <= `DHG_MASTER_DBG;
        end else if (ce_i) begin
            trace_allow_o <= noninvasive_dbg_allow_i; // R8
            ap_bus_req_o <= apctl[`DHG_APCTL_XFER] & ap_mem_access_allow_i; // R9
            if (ap_master_id_lock_i || apctl[`DHG_APCTL_KIND]) begin
                ap_hmaster_o <= `DHG_MASTER_DBG; // R10 R11
            end else begin
                ap_hmaster_o <= `DHG_MASTER_CORE; // R12
            end
        end
    end

    // ==========================================================
    // debug port pin synchronisers
    always @(posedge clk_i) begin
        if (!nrst_i) begin
            tck_sync <= 3'h0;
            trst_sync <= 2'h0;
            tms_sync <= 2'h3;
            tdi_sync <= 2'h0;
        end else if (ce_i) begin
            tck_sync <= {tck_sync[1:0], dbg_port_clock_i}; // R16
            trst_sync <= {trst_sync[0], dbg_tap_reset_n_i};
            tms_sync <= {tms_sync[0], tms_i};
            tdi_sync <= {tdi_sync[0], tdi_i};
        end
    end

    assign tck_rise = tck_sync[1] & ~tck_sync[2];
    assign tck_fall = ~tck_sync[1] & tck_sync[2];

    dhg_tap u_tap (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .ce_i(ce_i),
        .tck_rise_i(tck_rise),
        .tap_rst_i(~trst_sync[1]),
        .tms_i(tms_sync[1]),
        .state_o(tap_state)
    );

    assign tap_top = (tap_state == `DHG_TAP_TLR) | (tap_state == `DHG_TAP_RTI) |
        (tap_state == `DHG_TAP_SDR) | (tap_state == `DHG_TAP_SIR); // R14
    assign shifting = (tap_state == `DHG_TAP_SHDR) | (tap_state == `DHG_TAP_SHIR);

    // ==========================================================
    // debug port outputs; data change on falling port clock edges
    always @(posedge clk_i) begin
        if (!nrst_i) begin
            port_proto_select_o <= 1'b0;
            tap_top_state_flag_o <= 1'b1;
            sw_data_out_o <= 1'b0;
            sw_data_out_en_o <= 1'b0;
            tdo_o <= 1'b0;
            tdo_shift <= 1'b0;
            tdo_pad_en_n_o <= 1'b1;
        end else if (ce_i) begin
            port_proto_select_o <= ctrl[`DHG_CTRL_JTAG_SEL]; // R13
            tap_top_state_flag_o <= tap_top;
            if (tck_rise && shifting) begin
                tdo_shift <= tdi_sync[1];
            end
            if (tck_fall) begin
                tdo_o <= tdo_shift; // R15
                tdo_pad_en_n_o <= ~(shifting & ctrl[`DHG_CTRL_JTAG_SEL]); // R15
                sw_data_out_o <= tdo_shift;
                sw_data_out_en_o <= ~ctrl[`DHG_CTRL_JTAG_SEL] & shifting; // R15
            end
        end
    end

endmodule
`default_nettype wire

// File: dhg_regs.vh
// dhg_regs.vh - constants for the debug halt and access gating block.
// assumes: included by bare name from the design files of this block.
//
// Contract
// R1 - external halt request arrives already synchronous to the core clock.
// R2 - external and trace macrocell halt requests are merged into one halt source.
// R3 - halted core leaves halt only when halt-exit request drops during handshake.
// R4 - requester watches halt-exit acknowledge and sequences its request against it.
// R5 - request up, ack up, request down, ack down; no new request until ack low.
// R6 - invasive permission low disables halting from every source.
// R7 - halts need both invasive permission and the core halt enable bit.
// R8 - instruction trace allowed only while noninvasive permission is high.
// R9 - memory permission low: access port registers reachable, no system transfers.
// R10 - access port master id is 1 for debugger, 0 to mimic data side.
// R11 - master id lock high forces master id 1 regardless of kind bit.
// R12 - master id lock low lets the kind bit choose master id.
// R13 - protocol select output high in JTAG mode, low in serial-wire mode.
// R14 - top-state flag high in reset, idle, select-DR and select-IR states.
// R15 - serial-wire data out with enable; test data out with active-low pad enable.
// R16 - debug port logic runs from its own, possibly asynchronous, clock.
// R17 - TAP reset initialises the TAP without disturbing the core.
// R18 - halted flag stays high for the whole time the core is halted.
`ifndef DHG_REGS_VH
`define DHG_REGS_VH

// ==========================================================
// register map
`define DHG_ADDR_W 4
`define DHG_REG_CTRL 4'h0
`define DHG_REG_STAT 4'h4
`define DHG_REG_APCTL 4'h8

// ==========================================================
// control register fields
`define DHG_CTRL_HALT_EN 0
`define DHG_CTRL_HALT_REQ 1
`define DHG_CTRL_JTAG_SEL 2
`define DHG_CTRL_RESET 3'h0
`define DHG_CTRL_W 3

// access port control fields
`define DHG_APCTL_KIND 0
`define DHG_APCTL_XFER 1
`define DHG_APCTL_RESET 2'h0
`define DHG_APCTL_W 2

// status register fields
`define DHG_STAT_HALTED 0
`define DHG_STAT_ACK 1
`define DHG_STAT_JTAG 2
`define DHG_STAT_TOP 3
`define DHG_STAT_W 8

// ==========================================================
// master identity values
`define DHG_MASTER_DBG 4'h1
`define DHG_MASTER_CORE 4'h0

// tap state encoding
`define DHG_TAP_W 4
`define DHG_TAP_TLR 4'hF
`define DHG_TAP_RTI 4'hC
`define DHG_TAP_SDR 4'h7
`define DHG_TAP_CDR 4'h6
`define DHG_TAP_SHDR 4'h2
`define DHG_TAP_E1DR 4'h1
`define DHG_TAP_PDR 4'h3
`define DHG_TAP_E2DR 4'h0
`define DHG_TAP_UDR 4'h5
`define DHG_TAP_SIR 4'h4
`define DHG_TAP_CIR 4'hE
`define DHG_TAP_SHIR 4'hA
`define DHG_TAP_E1IR 4'h9
`define DHG_TAP_PIR 4'hB
`define DHG_TAP_E2IR 4'h8
`define DHG_TAP_UIR 4'hD

`endif

// File: dhg_tap.v
// dhg_tap.v - TAP state controller of the debug port.
// assumes: enable pulses mark rising edges of the sampled debug port clock.
`timescale 1ns/100ps
`default_nettype none
`include "dhg_regs.vh"

module dhg_tap (
    input wire clk_i,
    input wire nrst_i,
    input wire ce_i,
    input wire tck_rise_i,
    input wire tap_rst_i,
    input wire tms_i,
    output reg [`DHG_TAP_W-1:0] state_o
);

    reg [`DHG_TAP_W-1:0] next_state;

    // ==========================================================
    // next state from tms
    always @* begin
        case (state_o)
            `DHG_TAP_TLR: next_state = tms_i ? `DHG_TAP_TLR : `DHG_TAP_RTI;
            `DHG_TAP_RTI: next_state = tms_i ? `DHG_TAP_SDR : `DHG_TAP_RTI;
            `DHG_TAP_SDR: next_state = tms_i ? `DHG_TAP_SIR : `DHG_TAP_CDR;
            `DHG_TAP_CDR: next_state = tms_i ? `DHG_TAP_E1DR : `DHG_TAP_SHDR;
            `DHG_TAP_SHDR: next_state = tms_i ? `DHG_TAP_E1DR : `DHG_TAP_SHDR;
            `DHG_TAP_E1DR: next_state = tms_i ? `DHG_TAP_UDR : `DHG_TAP_PDR;
            `DHG_TAP_PDR: next_state = tms_i ? `DHG_TAP_E2DR : `DHG_TAP_PDR;
            `DHG_TAP_E2DR: next_state = tms_i ? `DHG_TAP_UDR : `DHG_TAP_SHDR;
            `DHG_TAP_UDR: next_state = tms_i ? `DHG_TAP_SDR : `DHG_TAP_RTI;
            `DHG_TAP_SIR: next_state = tms_i ? `DHG_TAP_TLR : `DHG_TAP_CIR;
            `DHG_TAP_CIR: next_state = tms_i ? `DHG_TAP_E1IR : `DHG_TAP_SHIR;
            `DHG_TAP_SHIR: next_state = tms_i ? `DHG_TAP_E1IR : `DHG_TAP_SHIR;
            `DHG_TAP_E1IR: next_state = tms_i ? `DHG_TAP_UIR : `DHG_TAP_PIR;
            `DHG_TAP_PIR: next_state = tms_i ? `DHG_TAP_E2IR : `DHG_TAP_PIR;
            `DHG_TAP_E2IR: next_state = tms_i ? `DHG_TAP_UIR : `DHG_TAP_SHIR;
            `DHG_TAP_UIR: next_state = tms_i ? `DHG_TAP_SDR : `DHG_TAP_RTI;
            default: next_state = `DHG_TAP_TLR;
        endcase
    end

    // ==========================================================
    // state register; tap reset touches only this controller
    always @(posedge clk_i) begin
        if (!nrst_i) begin
            state_o <= `DHG_TAP_TLR;
        end else if (ce_i) begin
            if (tap_rst_i) begin
                state_o <= `DHG_TAP_TLR; // R17
            end else if (tck_rise_i) begin
                state_o <= next_state; // R16
            end
        end
    end

endmodule
`default_nettype wire

// File: dhg_chk.sv
// dhg_chk.sv: port assertions for the halt and gating block.
// assumes: one clock domain; bound into dhg_top below.
`timescale 1ns/100ps
`default_nettype none
module dhg_chk (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic halt_exit_req_i,
    input wire logic halt_exit_ack_o,
    input wire logic core_halted_flag_o,
    input wire logic invasive_dbg_allow_i,
    input wire logic noninvasive_dbg_allow_i,
    input wire logic ap_mem_access_allow_i,
    input wire logic ap_master_id_lock_i,
    input wire logic trace_allow_o,
    input wire logic ap_bus_req_o,
    input wire logic [3:0] ap_hmaster_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);
    // =====
    // restart handshake steps
    sequence s_ask;
        core_halted_flag_o && halt_exit_req_i && ce_i;
    endsequence
    sequence s_drop;
        halt_exit_ack_o && !halt_exit_req_i && ce_i;
    endsequence
    AST_ACK_UP: assert property (s_ask |=> halt_exit_ack_o)
        else $error("ack missing");
    AST_EXIT: assert property (s_drop |=> !halt_exit_ack_o && !core_halted_flag_o)
        else $error("exit late");
    AST_STAY: assert property (core_halted_flag_o && !(halt_exit_ack_o && !halt_exit_req_i)
        |=> core_halted_flag_o) else $error("halt lost");
    AST_ACK_HALT: assert property (halt_exit_ack_o |-> core_halted_flag_o)
        else $error("ack while running");
    // =====
    // permissions and gating
    AST_NO_PERMIT: assert property (!invasive_dbg_allow_i && !core_halted_flag_o
        |=> !core_halted_flag_o) else $error("halt without permission");
    AST_TRACE: assert property (ce_i |=> trace_allow_o == $past(noninvasive_dbg_allow_i))
        else $error("trace permission wrong");
    AST_GATE: assert property (!ap_mem_access_allow_i && ce_i |=> !ap_bus_req_o)
        else $error("transfer while gated");
    AST_LOCK: assert property (ap_master_id_lock_i && ce_i |=> ap_hmaster_o == 4'h1)
        else $error("master id not locked");
endmodule
bind dhg_top dhg_chk u_chk (.clk_i, .nrst_i, .ce_i, .halt_exit_req_i, .halt_exit_ack_o,
    .core_halted_flag_o, .invasive_dbg_allow_i, .noninvasive_dbg_allow_i,
    .ap_mem_access_allow_i, .ap_master_id_lock_i, .trace_allow_o, .ap_bus_req_o,
    .ap_hmaster_o);
`default_nettype wire

// File: dhg_dbg_model.sv
// dhg_dbg_model.sv: debugger model, restart handshake and port clock.
// assumes: core clock from the bench; ack is sampled on rising edges.
`timescale 1ns/100ps
`default_nettype none
module dhg_dbg_model (
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic [1:0] lag_i,
    input wire logic frame_i,
    input wire logic halt_exit_ack_i,
    output logic halt_exit_req_o,
    output logic done_o,
    output logic dbg_port_clock_o
);
    int n;
    // four-phase restart, each level held until the ack is seen
    initial begin
        halt_exit_req_o = 1'b0;
        done_o = 1'b0;
        forever begin
            @(posedge clk_i);
            done_o <= 1'b0;
            if (go_i === 1'b1) begin
                repeat (lag_i) @(posedge clk_i);
                halt_exit_req_o <= 1'b1;
                for (n = 0; n < 40 && halt_exit_ack_i !== 1'b1; n++) @(posedge clk_i);
                repeat (lag_i) @(posedge clk_i);
                halt_exit_req_o <= 1'b0;
                for (n = 0; n < 40 && halt_exit_ack_i !== 1'b0; n++) @(posedge clk_i);
                done_o <= 1'b1;
            end
        end
    end
    // port clock, unrelated phase, rests low outside frames
    initial begin
        dbg_port_clock_o = 1'b0;
        #3.3;
        forever begin
            #80;
            dbg_port_clock_o = frame_i ? ~dbg_port_clock_o : 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: dhg_top_tb.sv
// dhg_top_tb.sv: self-checking bench for the halt and gating block.
// assumes: dhg_dbg_model plays the debugger; dhg_chk is bound in.
`timescale 1ns/100ps
`default_nettype none
`include "dhg_regs.vh"
module dhg_top_tb;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic ce_i = 1'b1;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00;
    logic ext_halt_req_i = 1'b0;
    logic trace_halt_req_i = 1'b0;
    logic invasive_dbg_allow_i = 1'b0;
    logic noninvasive_dbg_allow_i = 1'b0;
    logic ap_mem_access_allow_i = 1'b0;
    logic ap_master_id_lock_i = 1'b0;
    logic dbg_tap_reset_n_i = 1'b0;
    logic tms_i = 1'b1;
    logic tdi_i = 1'b0;
    logic go = 1'b0;
    logic frame = 1'b0;
    logic [1:0] lag = 2'h0;
    logic [3:0] k;
    logic [16:0] tms_seq = 17'h185F5;
    logic [16:0] top_seq = 17'h007C7;
    logic [16:0] sh_seq = 17'h07000;
    logic b, sh;
    int q[$] = '{0};
    logic [7:0] rdata_o;
    logic [3:0] ap_hmaster_o;
    logic halt_exit_req_i, halt_exit_ack_o, core_halted_flag_o, trace_allow_o, ap_bus_req_o;
    logic port_proto_select_o, tap_top_state_flag_o, sw_data_out_o, sw_data_out_en_o;
    logic tdo_o, tdo_pad_en_n_o, done, dbg_port_clock_i;
    int num_errors = 0;
    int total_checks = 0;
    int i, e, s, m;
    dhg_top dut (.clk_i, .nrst_i, .ce_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .ext_halt_req_i, .trace_halt_req_i, .halt_exit_req_i, .halt_exit_ack_o,
        .core_halted_flag_o, .invasive_dbg_allow_i, .noninvasive_dbg_allow_i,
        .ap_mem_access_allow_i, .ap_master_id_lock_i, .trace_allow_o, .ap_bus_req_o,
        .ap_hmaster_o, .dbg_port_clock_i, .dbg_tap_reset_n_i, .tms_i, .tdi_i,
        .port_proto_select_o, .tap_top_state_flag_o, .sw_data_out_o, .sw_data_out_en_o,
        .tdo_o, .tdo_pad_en_n_o);
    dhg_dbg_model u_dbg (.clk_i, .go_i(go), .lag_i(lag), .frame_i(frame),
        .halt_exit_ack_i(halt_exit_ack_o), .halt_exit_req_o(halt_exit_req_i),
        .done_o(done), .dbg_port_clock_o(dbg_port_clock_i));
    // =====
    // clock; test data follow the port clock in the tap walk
    always #4 clk_i = ~clk_i;
    // =====
    // shared tasks
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        total_checks++;
        if (seen !== want) begin
            num_errors++;
            $display("BAD %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic wait_lvl(input int sel, input logic lvl);
        int n;
        for (n = 0; n < 60 && (sel ? done : dbg_port_clock_i) !== lvl; n++) @(posedge clk_i);
        if (n == 60) begin
            num_errors++;
            close_out();
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] want);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(posedge clk_i);
        check(rdata_o, want);
    endtask
    task automatic restart(input logic [1:0] l);
        @(posedge clk_i);
        lag <= l;
        go <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
        wait_lvl(1, 1'b1);
        check(core_halted_flag_o, 1'b0);
        check(halt_exit_ack_o, 1'b0);
    endtask
    // =====
    // main sequence
    initial begin
        void'($urandom(32'hc5a74b03));
        repeat (5) @(posedge clk_i);
        nrst_i <= 1'b1;
        dbg_tap_reset_n_i <= 1'b1;
        @(posedge clk_i);
        check(tap_top_state_flag_o, 1'b1);
        check(tdo_pad_en_n_o, 1'b1);
        check(ap_hmaster_o, 4'h1);
        wr(4'hC, 8'hFF);
        rd(4'hC, 8'h00);
        wr(`DHG_REG_STAT, 8'hFF);
        rd(`DHG_REG_STAT, 8'h08);
        // master identity, memory gating and trace permission, all 16 combinations in turn from a random start
        s = $urandom % 16;
        for (i = 0; i < 16; i++) begin
            k = 4'(i + s);
            wr(`DHG_REG_APCTL, {6'h00, k[3], k[1]});
            ap_master_id_lock_i <= k[0];
            ap_mem_access_allow_i <= k[2];
            noninvasive_dbg_allow_i <= k[2];
            repeat (3) @(posedge clk_i);
            check(ap_hmaster_o, {3'h0, k[0] | k[1]});
            check(ap_bus_req_o, k[3] & k[2]);
            check(trace_allow_o, k[2]);
        end
        rd(`DHG_REG_APCTL, {6'h00, k[3], k[1]});
        // clock enable low freezes the registered outputs
        ce_i <= 1'b0;
        noninvasive_dbg_allow_i <= !k[2];
        repeat (3) @(posedge clk_i);
        check(trace_allow_o, k[2]);
        ce_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        check(trace_allow_o, !k[2]);
        // every halt source against both permissions, restart when halted
        for (e = 0; e < 4; e++) begin
            for (s = 0; s < 3; s++) begin
                invasive_dbg_allow_i <= e[0];
                wr(`DHG_REG_CTRL, {6'h00, s == 2, e[1]});
                ext_halt_req_i <= (s == 0);
                trace_halt_req_i <= (s == 1);
                repeat (3) @(posedge clk_i);
                check(core_halted_flag_o, e == 3);
                ext_halt_req_i <= 1'b0;
                trace_halt_req_i <= 1'b0;
                dbg_tap_reset_n_i <= 1'b0;
                rd(`DHG_REG_STAT, {7'h04, e == 3});
                dbg_tap_reset_n_i <= 1'b1;
                wr(`DHG_REG_CTRL, {7'h00, e[1]});
                check(core_halted_flag_o, e == 3);
                if (e == 3) restart(2'($urandom));
            end
        end
        // tap walk through top, shift and update states, jtag mode then serial-wire mode;
        // q models the one-bit path: a bit taken on a rise in a shift state leaves on falls
        for (m = 1; m >= 0; m--) begin
            wr(`DHG_REG_CTRL, {5'h00, m[0], 2'h0});
            repeat (2) @(posedge clk_i);
            check(port_proto_select_o, m[0]);
            frame <= 1'b1;
            sh = 1'b0;
            for (i = 0; i < 17; i++) begin
                wait_lvl(0, 1'b1);
                wait_lvl(0, 1'b0);
                repeat (4) @(posedge clk_i);
                check(tdo_o, q[$]);
                check(sw_data_out_o, q[$]);
                check(tdo_pad_en_n_o, !(m[0] && sh));
                check(sw_data_out_en_o, !m[0] && sh);
                b = 1'($urandom);
                if (sh) q.push_back(b);
                tms_i <= tms_seq[i];
                tdi_i <= b;
                wait_lvl(0, 1'b1);
                repeat (6) @(posedge clk_i);
                check(tap_top_state_flag_o, top_seq[i]);
                sh = sh_seq[i];
            end
            // walk ends in update-DR; the tap reset alone must bring it back to the top
            frame <= 1'b0;
            dbg_tap_reset_n_i <= 1'b0;
            repeat (6) @(posedge clk_i);
            check(tap_top_state_flag_o, 1'b1);
            dbg_tap_reset_n_i <= 1'b1;
        end
        close_out();
    end
endmodule
`default_nettype wire
